// ==== hdl/gp_pkg.sv ====
// Package with register map, command codes, status bits and timing for the gripper.
package gp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the Wishbone bus.
  localparam logic [7:0] OFS_COMMAND  = 8'h00;
  localparam logic [7:0] OFS_PROFILE  = 8'h04;
  localparam logic [7:0] OFS_RECIPE   = 8'h08;
  localparam logic [7:0] OFS_FORCE    = 8'h0C;
  localparam logic [7:0] OFS_SPEED    = 8'h10;
  localparam logic [7:0] OFS_WINDOW   = 8'h14;
  localparam logic [7:0] OFS_OUTER    = 8'h18;
  localparam logic [7:0] OFS_INNER    = 8'h1C;
  localparam logic [7:0] OFS_PART     = 8'h20;
  localparam logic [7:0] OFS_STATUS   = 8'h24;
  localparam logic [7:0] OFS_FAULT    = 8'h28;
  localparam logic [7:0] OFS_POSITION = 8'h2C;

  ////////////////////////////////////////////////////////////////////////////
  // Command image values.
  localparam logic [15:0] CMD_IDLE      = 16'h0000;
  localparam logic [15:0] CMD_TRANSFER  = 16'h0001;
  localparam logic [15:0] CMD_CLEAR_DIR = 16'h0004;
  localparam logic [15:0] CMD_OPEN      = 16'h0100;
  localparam logic [15:0] CMD_CLOSE     = 16'h0200;

  ////////////////////////////////////////////////////////////////////////////
  // Status image bit positions.
  localparam int BIT_HOMED     = 0;
  localparam int BIT_MOTOR_ON  = 1;
  localparam int BIT_IN_MOTION = 2;
  localparam int BIT_COMPLETE  = 3;
  localparam int BIT_BOOTED    = 6;
  localparam int BIT_AT_OUTER  = 8;
  localparam int BIT_AT_PART   = 9;
  localparam int BIT_AT_INNER  = 10;
  localparam int BIT_UNDEF_POS = 11;
  localparam int BIT_XFER_ACK  = 12;
  localparam int BIT_DIR_OUT   = 13;
  localparam int BIT_DIR_IN    = 14;
  localparam int BIT_ERROR     = 15;

  ////////////////////////////////////////////////////////////////////////////
  // Fault codes, profile and recipe values.
  localparam logic [15:0] FAULT_NONE     = 16'h0000;
  localparam logic [15:0] FAULT_BLOCKED  = 16'h0307;
  localparam logic [7:0]  PROFILE_UNIV   = 8'h67;
  localparam logic [7:0]  RECIPE_CURRENT = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values of the parameter registers.
  localparam logic [15:0] RST_COMMAND  = 16'h0000;
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [15:0] RST_POSITION = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: clock rate, boot delay and time per 0.01 mm jaw step.
  localparam int CLK_MHZ      = 125;
  localparam int BOOT_TIME_US = 200;
  localparam int BOOT_CYCLES  = BOOT_TIME_US * CLK_MHZ;
  localparam int STEP_TIME_NS = 800;
  localparam int STEP_CYCLES  = (STEP_TIME_NS * CLK_MHZ + 999) / 1000;

  ////////////////////////////////////////////////////////////////////////////
  // Controller states.
  typedef enum logic [2:0] {
    ST_BOOT = 3'b001,
    ST_IDLE = 3'b010,
    ST_MOVE = 3'b100
  } gp_state_e;

endpackage : gp_pkg

// ==== hdl/gp_tick.sv ====
// Free-running divider giving one-cycle pulses every PERIOD clocks.
module gp_tick
#(
  parameter int PERIOD = 100
)
(
  // Clock and reset
  input  wire logic I_MCLK,
  input  wire logic I_RST_N,
  // Pulse output
  output logic      o_tick
);

  localparam int W = (PERIOD > 1) ? $clog2(PERIOD) : 1;
  localparam logic [W-1:0] LAST = W'(PERIOD - 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } gp_tick_s;

  gp_tick_s r_q;
  gp_tick_s r_d;

  always_comb
  begin
    r_d      = r_q;
    r_d.tick = (r_q.cnt == LAST);
    r_d.cnt  = (r_q.cnt == LAST) ? '0 : r_q.cnt + W'(1);
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      r_q <= '0;
    else
      r_q <= r_d;
  end

  assign o_tick = r_q.tick;

endmodule // gp_tick

// ==== hdl/gp_window.sv ====
// Tolerance window compare of the jaw position against one target.
module gp_window
#(
  parameter int W = 16
)
(
  // Operands
  input  wire logic [W-1:0] i_pos,
  input  wire logic [W-1:0] i_target,
  input  wire logic [7:0]   i_tol,
  // Result
  output logic              o_hit
);

  logic [W-1:0] diff;

  // Absolute distance, so the window acts in both directions.
  always_comb
  begin
    diff  = (i_pos >= i_target) ? i_pos - i_target : i_target - i_pos;
    o_hit = (diff <= W'(i_tol));
  end

endmodule // gp_window

// ==== hdl/gp_gripper.sv ====
// Command interpreter and status reporting of the electric parallel gripper.
//
// Operation
// - Report active fault code as 16 bits
// - Report jaw position in 0.01 mm units
// - Keep position between outer and inner target
// - Start reporting right after boot completes
// - Set transfer acknowledge after taking parameters
// - Clear acknowledge on release; host waits
// - Command 0x0200 drives jaws inward
// - Command 0x0100 drives jaws outward
// - New handshake aborts running motion
// - Set bits 8, 9, 10 at positions
// - Sticky direction flags alternate per move
// - Refuse repeat move in flagged direction
// - Command 0x0004 clears bits 13, 14
// - Blocked move reports fault 0x307
// - Recipe index 0 uses transferred parameters
// - Profile 103 selects universal mode
// - Bit 13 outward, bit 14 inward
// - Booted flag bit 6 after boot
//
// The implementer's own choices: register access over Wishbone and the register addresses.
module gp_gripper
  import gp_pkg::*;
#(
  parameter int BOOT_CLKS = BOOT_CYCLES,
  parameter int STEP_CLKS = STEP_CYCLES,
  parameter int POS_W     = 16
)
(
  // Clock and reset
  input  wire logic              I_MCLK,
  input  wire logic              I_RST_N,
  // Wishbone slave
  input  wire logic              I_WB_CYC,
  input  wire logic              I_WB_STB,
  input  wire logic              I_WB_WE,
  input  wire logic [7:0]        I_WB_ADR,
  input  wire logic [3:0]        I_WB_SEL,
  input  wire logic [31:0]       I_WB_DAT,
  output logic      [31:0]       O_WB_DAT,
  output logic                   O_WB_ACK,
  // Drive feedback
  input  wire logic              I_JAW_BLOCKED,
  // Cyclic process data and drive outputs
  output logic      [15:0]       O_STATUS_IMAGE,
  output logic      [15:0]       O_FAULT_CODE,
  output logic      [POS_W-1:0]  O_JAW_POSITION,
  output logic                   O_DRIVE_IN,
  output logic                   O_DRIVE_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the block.

  typedef struct packed {
    gp_state_e        state;
    logic             ack;
    logic [31:0]      rdat;
    logic [15:0]      command_image;
    logic [7:0]       profile_select;
    logic [7:0]       recipe_index;
    logic [7:0]       force_level;
    logic [7:0]       speed_level;
    logic [7:0]       position_window;
    logic [POS_W-1:0] outer_target;
    logic [POS_W-1:0] inner_target;
    logic [POS_W-1:0] part_target;
    logic [7:0]       act_profile;
    logic [7:0]       act_window;
    logic [POS_W-1:0] act_outer;
    logic [POS_W-1:0] act_inner;
    logic [POS_W-1:0] act_part;
    logic             params_ok;
    logic             transfer_ack;
    logic             flag_out;
    logic             flag_in;
    logic             move_in;
    logic             complete;
    logic             drive_in;
    logic             drive_out;
    logic [15:0]      fault_code;
    logic [POS_W-1:0] jaw_position;
    logic [15:0]      status_image;
  } gp_regs_s;

  gp_regs_s r_q;
  gp_regs_s r_d;

  logic boot_tick;
  logic step_tick;
  logic hit_outer;
  logic hit_inner;
  logic hit_part;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers: boot delay, step rate and the three position windows.

  gp_tick #(.PERIOD (BOOT_CLKS)) u_boot_timer (
    .I_MCLK  (I_MCLK),
    .I_RST_N (I_RST_N),
    .o_tick  (boot_tick)
  );

  gp_tick #(.PERIOD (STEP_CLKS)) u_step_timer (
    .I_MCLK  (I_MCLK),
    .I_RST_N (I_RST_N),
    .o_tick  (step_tick)
  );

  gp_window #(.W (POS_W)) u_win_outer (
    .i_pos    (r_q.jaw_position),
    .i_target (r_q.act_outer),
    .i_tol    (r_q.act_window),
    .o_hit    (hit_outer)
  );

  gp_window #(.W (POS_W)) u_win_part (
    .i_pos    (r_q.jaw_position),
    .i_target (r_q.act_part),
    .i_tol    (r_q.act_window),
    .o_hit    (hit_part)
  );

  gp_window #(.W (POS_W)) u_win_inner (
    .i_pos    (r_q.jaw_position),
    .i_target (r_q.act_inner),
    .i_tol    (r_q.act_window),
    .o_hit    (hit_inner)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge for the 16-bit registers; upper lanes are ignored.

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wdat,
                                          input logic [3:0]  sel);
    logic [15:0] res;
    res = old;
    if (sel[0])
      res[7:0] = wdat[7:0];
    if (sel[1])
      res[15:8] = wdat[15:8];
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  logic        bus_req;
  logic        bus_wr;
  logic        cmd_close;
  logic        cmd_open;
  logic        at_target;
  logic [15:0] stat;

  always_comb
  begin
    r_d       = r_q;
    bus_req   = I_WB_CYC && I_WB_STB && !r_q.ack;
    bus_wr    = bus_req && I_WB_WE;
    cmd_close = (r_q.command_image == CMD_CLOSE);
    cmd_open  = (r_q.command_image == CMD_OPEN);
    at_target = r_q.move_in ? (r_q.jaw_position >= r_q.act_inner)
                            : (r_q.jaw_position <= r_q.act_outer);
    stat      = '0;

    // Bus: one registered answer per request, ack one cycle after the request and dropped the next cycle.
    r_d.ack  = bus_req;
    r_d.rdat = '0;
    if (bus_req && !I_WB_WE)
    begin
      case (I_WB_ADR)
        OFS_COMMAND:  r_d.rdat = {16'h0000, r_q.command_image};
        OFS_PROFILE:  r_d.rdat = {24'h00_0000, r_q.profile_select};
        OFS_RECIPE:   r_d.rdat = {24'h00_0000, r_q.recipe_index};
        OFS_FORCE:    r_d.rdat = {24'h00_0000, r_q.force_level};
        OFS_SPEED:    r_d.rdat = {24'h00_0000, r_q.speed_level};
        OFS_WINDOW:   r_d.rdat = {24'h00_0000, r_q.position_window};
        OFS_OUTER:    r_d.rdat = 32'(r_q.outer_target);
        OFS_INNER:    r_d.rdat = 32'(r_q.inner_target);
        OFS_PART:     r_d.rdat = 32'(r_q.part_target);
        OFS_STATUS:   r_d.rdat = {16'h0000, r_q.status_image};
        OFS_FAULT:    r_d.rdat = {16'h0000, r_q.fault_code};
        OFS_POSITION: r_d.rdat = 32'(r_q.jaw_position);
        default:      r_d.rdat = '0;
      endcase
    end
    if (bus_wr)
    begin
      case (I_WB_ADR)
        OFS_COMMAND:
          r_d.command_image = merge16(r_q.command_image, I_WB_DAT, I_WB_SEL);
        OFS_PROFILE: if (I_WB_SEL[0]) r_d.profile_select = I_WB_DAT[7:0];
        OFS_RECIPE: if (I_WB_SEL[0]) r_d.recipe_index = I_WB_DAT[7:0];
        OFS_FORCE: if (I_WB_SEL[0]) r_d.force_level = I_WB_DAT[7:0];
        OFS_SPEED: if (I_WB_SEL[0]) r_d.speed_level = I_WB_DAT[7:0];
        OFS_WINDOW: if (I_WB_SEL[0]) r_d.position_window = I_WB_DAT[7:0];
        OFS_OUTER:
          r_d.outer_target = POS_W'(merge16(16'(r_q.outer_target),
                                            I_WB_DAT, I_WB_SEL));
        OFS_INNER:
          r_d.inner_target = POS_W'(merge16(16'(r_q.inner_target),
                                            I_WB_DAT, I_WB_SEL));
        OFS_PART:
          r_d.part_target = POS_W'(merge16(16'(r_q.part_target),
                                           I_WB_DAT, I_WB_SEL));
        default: ;
      endcase
    end

    // Controller. Commands are judged from the stored command image.
    case (r_q.state)
      ST_BOOT:
        if (boot_tick)
          r_d.state = ST_IDLE;
      ST_IDLE, ST_MOVE:
      begin
        if (r_q.command_image == CMD_TRANSFER && !r_q.transfer_ack)
        begin
          // Only the live parameter set exists; stored recipes are absent.
          if (r_q.recipe_index == RECIPE_CURRENT)
          begin
            r_d.act_profile = r_q.profile_select;
            r_d.act_window  = r_q.position_window;
            r_d.act_outer   = r_q.outer_target;
            r_d.act_inner   = r_q.inner_target;
            r_d.act_part    = r_q.part_target;
            r_d.params_ok   = 1'b1;
            // Pull the reported position into the new travel range.
            if (r_q.jaw_position < r_q.outer_target)
              r_d.jaw_position = r_q.outer_target;
            else if (r_q.jaw_position > r_q.inner_target)
              r_d.jaw_position = r_q.inner_target;
          end
          r_d.transfer_ack = 1'b1;
          r_d.state        = ST_IDLE;
          r_d.fault_code   = FAULT_NONE;
        end
        else if (r_q.command_image == CMD_IDLE && r_q.transfer_ack)
          r_d.transfer_ack = 1'b0;
        else if (r_q.command_image == CMD_CLEAR_DIR)
        begin
          r_d.flag_out = 1'b0;
          r_d.flag_in  = 1'b0;
        end
        else if (r_q.state == ST_IDLE)
        begin
          // A move starts only with a completed handshake and the
          // universal profile; the flag of that direction must be clear.
          if (r_q.params_ok && !r_q.transfer_ack &&
              r_q.act_profile == PROFILE_UNIV)
          begin
            if (cmd_close && !r_q.flag_in)
            begin
              r_d.state      = ST_MOVE;
              r_d.move_in    = 1'b1;
              r_d.flag_in    = 1'b1;
              r_d.flag_out   = 1'b0;
              r_d.complete   = 1'b0;
              r_d.fault_code = FAULT_NONE;
            end
            else if (cmd_open && !r_q.flag_out)
            begin
              r_d.state      = ST_MOVE;
              r_d.move_in    = 1'b0;
              r_d.flag_out   = 1'b1;
              r_d.flag_in    = 1'b0;
              r_d.complete   = 1'b0;
              r_d.fault_code = FAULT_NONE;
            end
          end
        end
        else
        begin
          // Moving: the move ends once its command is dropped, unless the new command is CMD_CLEAR_DIR, which holds ST_MOVE without steps.
          if (r_q.move_in ? !cmd_close : !cmd_open)
            r_d.state = ST_IDLE;
          else if (at_target)
          begin
            r_d.state    = ST_IDLE;
            r_d.complete = 1'b1;
          end
          else if (step_tick && I_JAW_BLOCKED)
          begin
            r_d.state      = ST_IDLE;
            r_d.fault_code = FAULT_BLOCKED;
          end
          else if (step_tick)
          begin
            // Steps stay inside [outer, inner], never passing a target.
            if (r_q.move_in)
              r_d.jaw_position = r_q.jaw_position + POS_W'(1);
            else
              r_d.jaw_position = r_q.jaw_position - POS_W'(1);
          end
        end
      end
      default:
        r_d.state = ST_BOOT;
    endcase

    // Status image, refreshed every cycle once booted.
    if (r_q.state != ST_BOOT)
    begin
      stat[BIT_HOMED]     = 1'b1;
      stat[BIT_MOTOR_ON]  = (r_q.state == ST_MOVE);
      stat[BIT_IN_MOTION] = (r_q.state == ST_MOVE);
      stat[BIT_COMPLETE]  = r_q.complete;
      stat[BIT_BOOTED]    = 1'b1;
      stat[BIT_AT_OUTER]  = r_q.params_ok && hit_outer;
      stat[BIT_AT_PART]   = r_q.params_ok && hit_part;
      stat[BIT_AT_INNER]  = r_q.params_ok && hit_inner;
      stat[BIT_UNDEF_POS] = !(r_q.params_ok &&
                              (hit_outer || hit_part || hit_inner));
      stat[BIT_XFER_ACK]  = r_q.transfer_ack;
      stat[BIT_DIR_OUT]   = r_q.flag_out;
      stat[BIT_DIR_IN]    = r_q.flag_in;
      stat[BIT_ERROR]     = (r_q.fault_code != FAULT_NONE);
    end
    r_d.status_image = stat;
    r_d.drive_in     = (r_q.state == ST_MOVE) && r_q.move_in;
    r_d.drive_out    = (r_q.state == ST_MOVE) && !r_q.move_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      r_q                 <= '0;
      r_q.state           <= ST_BOOT;
      r_q.command_image   <= RST_COMMAND;
      r_q.profile_select  <= RST_BYTE;
      r_q.recipe_index    <= RST_BYTE;
      r_q.force_level     <= RST_BYTE;
      r_q.speed_level     <= RST_BYTE;
      r_q.position_window <= RST_BYTE;
      r_q.jaw_position    <= RST_POSITION;
      r_q.fault_code      <= FAULT_NONE;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops.

  assign O_WB_ACK       = r_q.ack;
  assign O_WB_DAT       = r_q.rdat;
  assign O_STATUS_IMAGE = r_q.status_image;
  assign O_FAULT_CODE   = r_q.fault_code;
  assign O_JAW_POSITION = r_q.jaw_position;
  assign O_DRIVE_IN     = r_q.drive_in;
  assign O_DRIVE_OUT    = r_q.drive_out;

endmodule // gp_gripper

// ==== bench/gp_gripper_assertions.sv ====
// Port-level assertions for the gripper command interpreter.
module gp_gripper_assertions
  import gp_pkg::*;
#(
  parameter int BOOT_CLKS = 20,
  parameter int POS_W     = 16
)
(
  // Clock, reset and bus
  input  wire logic             I_MCLK,
  input  wire logic             I_RST_N,
  input  wire logic             I_WB_CYC,
  input  wire logic             I_WB_STB,
  input  wire logic             I_WB_WE,
  input  wire logic [7:0]       I_WB_ADR,
  input  wire logic [3:0]       I_WB_SEL,
  input  wire logic [31:0]      I_WB_DAT,
  input  wire logic [31:0]      O_WB_DAT,
  input  wire logic             O_WB_ACK,
  // Drive and process data
  input  wire logic             I_JAW_BLOCKED,
  input  wire logic [15:0]      O_STATUS_IMAGE,
  input  wire logic [15:0]      O_FAULT_CODE,
  input  wire logic [POS_W-1:0] O_JAW_POSITION,
  input  wire logic             O_DRIVE_IN,
  input  wire logic             O_DRIVE_OUT
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] st;
  logic [15:0] up_q;

  assign st = O_STATUS_IMAGE;

  // Cycles since reset release, saturating so it never wraps.
  always_ff @(posedge I_MCLK or negedge I_RST_N)
    if (!I_RST_N)
      up_q <= 16'h0000;
    else if (up_q != 16'hFFFF)
      up_q <= up_q + 16'h0001;

  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_N);

  // A command write is the edge at which its ack is sampled.
  sequence s_cmd(logic [15:0] v);
    I_WB_CYC && I_WB_STB && I_WB_WE && O_WB_ACK &&
    I_WB_ADR == OFS_COMMAND && I_WB_DAT[15:0] == v;
  endsequence

  AST_ACK_PULSE: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("bus ack held over one cycle");
  AST_ACK_CAUSE: assert property (O_WB_ACK |-> $past(I_WB_CYC && I_WB_STB))
    else $error("bus ack without request");
  AST_BOOT_EARLY: assert property (st[BIT_BOOTED]
    |-> up_q >= BOOT_CLKS)
    else $error("booted flag before boot time");
  AST_BOOT_LATE: assert property (up_q > BOOT_CLKS + 6
    |-> st[BIT_BOOTED])
    else $error("booted flag missing after boot");
  AST_XFER: assert property (s_cmd(CMD_TRANSFER) ##0 st[BIT_BOOTED]
    |-> ##[1:3] st[BIT_XFER_ACK])
    else $error("transfer not acknowledged");
  AST_RELEASE: assert property (s_cmd(CMD_IDLE)
    |-> ##[1:3] !st[BIT_XFER_ACK])
    else $error("transfer ack not cleared");
  AST_CLEAR: assert property (s_cmd(CMD_CLEAR_DIR) ##0 st[BIT_BOOTED]
    |-> ##[1:3] (st[14:13] == 2'b00))
    else $error("direction flags not cleared");
  AST_DIR_ONE: assert property (!(st[BIT_DIR_IN] && st[BIT_DIR_OUT]))
    else $error("both direction flags set");
  AST_FAULT_CODE: assert property (O_FAULT_CODE != FAULT_NONE
    |-> O_FAULT_CODE == FAULT_BLOCKED)
    else $error("unexpected fault code");
  AST_ERR_BIT: assert property (O_FAULT_CODE != FAULT_NONE
    |-> ##[0:1] st[BIT_ERROR])
    else $error("error bit missing with fault");
  AST_DRIVE_IN: assert property (O_DRIVE_IN
    |-> st[BIT_DIR_IN] && !O_DRIVE_OUT)
    else $error("inward drive without inward flag");
  AST_DRIVE_OUT: assert property (O_DRIVE_OUT |-> st[BIT_DIR_OUT])
    else $error("outward drive without outward flag");
endmodule // gp_gripper_assertions

bind gp_gripper gp_gripper_assertions #(.BOOT_CLKS(BOOT_CLKS), .POS_W(POS_W))
  gp_gripper_assertions_inst (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N),
  .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE),
  .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT),
  .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .I_JAW_BLOCKED(I_JAW_BLOCKED),
  .O_STATUS_IMAGE(O_STATUS_IMAGE), .O_FAULT_CODE(O_FAULT_CODE),
  .O_JAW_POSITION(O_JAW_POSITION), .O_DRIVE_IN(O_DRIVE_IN),
  .O_DRIVE_OUT(O_DRIVE_OUT));

// ==== bench/gp_jaw_model.sv ====
// Jaw mechanics: a workpiece that stalls the opening jaws at one point.
module gp_jaw_model
#(
  parameter int POS_W = 16
)
(
  // Clock
  input  wire logic             i_clk,
  // Stall set-up and drive state
  input  wire logic             i_stall_en,
  input  wire logic [POS_W-1:0] i_stall_at,
  input  wire logic             i_drive_out,
  input  wire logic [POS_W-1:0] i_pos,
  // Feedback
  output logic                  o_blocked
);
  timeunit 1ns;
  timeprecision 1ps;

  // Blocking drops one clock after the drive stops, like a real stall switch.
  always @(posedge i_clk)
    o_blocked <= i_stall_en && i_drive_out && (i_pos <= i_stall_at);
endmodule // gp_jaw_model

// ==== bench/test_gp_gripper.sv ====
// Self-checking bench for the gripper command interpreter.
module test_gp_gripper
  import gp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack;
  logic        blk;
  logic [15:0] status;
  logic [15:0] fault;
  logic [15:0] pos;
  logic        din;
  logic        dout;
  logic        stall_en = 1'b0;
  logic [15:0] stall_at = 16'h0010;
  logic [31:0] dummy;
  int          errors = 0;
  int          samples_checked = 0;
  logic [7:0]  ofs [8] = '{OFS_PROFILE, OFS_RECIPE, OFS_FORCE, OFS_SPEED,
                           OFS_WINDOW, OFS_OUTER, OFS_INNER, OFS_PART};
  logic [15:0] val [8] = '{16'h0067, 16'h0000, 16'h0004, 16'h0001,
                           16'h0000, 16'h000A, 16'h0014, 16'h000F};

  always #4 clk = ~clk;

  gp_gripper #(.BOOT_CLKS(20), .STEP_CLKS(4)) gp_gripper_inst (
    .I_MCLK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_JAW_BLOCKED(blk),
    .O_STATUS_IMAGE(status), .O_FAULT_CODE(fault), .O_JAW_POSITION(pos),
    .O_DRIVE_IN(din), .O_DRIVE_OUT(dout));

  gp_jaw_model gp_jaw_model_inst (.i_clk(clk), .i_stall_en(stall_en),
    .i_stall_at(stall_at), .i_drive_out(dout), .i_pos(pos),
    .o_blocked(blk));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [31:0] e,
                       input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  // One classic cycle; the request stands until ack is sampled.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hF;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wb(1'b1, a, {16'h0000, d}, dummy);
  endtask

  task automatic rdchk(input string n, input logic [7:0] a,
                       input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    check(n, e, q);
  endtask

  task automatic wait_st(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (status[b] !== v && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    check("status bit", {31'h0, v}, {31'h0, status[b]});
  endtask

  task automatic xfer();
    wr(OFS_COMMAND, CMD_TRANSFER);
    wait_st(BIT_XFER_ACK, 1'b1, 40);
    wr(OFS_COMMAND, CMD_IDLE);
    wait_st(BIT_XFER_ACK, 1'b0, 40);
  endtask

  task automatic print_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // The whole sequence needs under 2000 cycles; this is ten times that.
  initial
  begin
    #160000;
    errors++;
    print_verdict();
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("unmapped", 8'h30, 32'h0);
    wr(OFS_STATUS, 16'hFFFF);
    rdchk("profile reset", OFS_PROFILE, 32'h0);
    // Still booting here, so the image must be empty despite the write.
    check("status in boot", 32'h0, {16'h0, status});
    wait_st(BIT_BOOTED, 1'b1, 60);
    rdchk("boot status", OFS_STATUS, 32'h0000_0841);
    rdchk("fault reg", OFS_FAULT, 32'h0);
    // A move before any transfer must be ignored.
    wr(OFS_COMMAND, CMD_CLOSE);
    repeat (12) @(posedge clk);
    check("early move", 32'h0, {31'h0, status[BIT_IN_MOTION]});
    wr(OFS_COMMAND, CMD_IDLE);
    for (int i = 0; i < 8; i++)
      wr(ofs[i], val[i]);
    xfer();
    rdchk("clamped pos", OFS_POSITION, 32'h0000_000A);
    check("at outer", 32'h1, {31'h0, status[BIT_AT_OUTER]});
    wr(OFS_COMMAND, CMD_CLOSE);
    wait_st(BIT_AT_INNER, 1'b1, 200);
    check("inner pos", 32'h0014, {16'h0, pos});
    check("dir flags", 32'h2, {30'h0, status[14:13]});
    wr(OFS_COMMAND, CMD_IDLE);
    // Same direction again is refused while its flag stands.
    wr(OFS_COMMAND, CMD_CLOSE);
    repeat (12) @(posedge clk);
    check("repeat close", 32'h0, {31'h0, status[BIT_IN_MOTION]});
    wr(OFS_COMMAND, CMD_IDLE);
    stall_en <= 1'b1;
    wr(OFS_COMMAND, CMD_OPEN);
    wait_st(BIT_ERROR, 1'b1, 200);
    check("fault code", {16'h0, FAULT_BLOCKED}, {16'h0, fault});
    check("dir flags", 32'h1, {30'h0, status[14:13]});
    wr(OFS_COMMAND, CMD_IDLE);
    stall_en <= 1'b0;
    wr(OFS_COMMAND, CMD_CLEAR_DIR);
    wait_st(BIT_DIR_OUT, 1'b0, 20);
    check("flag in", 32'h0, {31'h0, status[BIT_DIR_IN]});
    wr(OFS_COMMAND, CMD_IDLE);
    wr(OFS_COMMAND, CMD_OPEN);
    wait_st(BIT_AT_OUTER, 1'b1, 200);
    check("outer pos", 32'h000A, {16'h0, pos});
    check("fault clear", 32'h0, {16'h0, fault});
    wr(OFS_COMMAND, CMD_IDLE);
    // A handshake in mid-move stops the jaws short of the target.
    wr(OFS_COMMAND, CMD_CLOSE);
    wait_st(BIT_IN_MOTION, 1'b1, 20);
    check("drive in", 32'h1, {31'h0, din});
    repeat (8) @(posedge clk);
    xfer();
    check("aborted", 32'h0, {31'h0, status[BIT_IN_MOTION]});
    check("short of inner", 32'h0, {31'h0, status[BIT_AT_INNER]});
    print_verdict();
  end
endmodule // test_gp_gripper
